// File: include/sprs_pkg.sv
package sprs_pkg;
	// ----------------------------------------
	// Widths and encodings
	// ----------------------------------------
	localparam int PC_W = 21;
	localparam int STK_DEPTH = 31;
	localparam int STK_PTR_W = 5;
	localparam logic [15:0] OP_PUSH = 16'h0005;
	localparam logic [15:0] OP_SWRESET = 16'h00ff;
	localparam logic [4:0] OP_REL_CALL_TOP = 5'h1b;
	localparam int REL_CALL_OFF_W = 11;
	localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [PC_W-1:0] PC_RST = 21'h000000;
	localparam logic [STK_PTR_W-1:0] SP_RST = 5'h00;
	localparam logic [1:0] QPH_RST = 2'h0;
	localparam logic [7:0] STATUS_RST = 8'h00;
	// Quarter-phase indices
	localparam logic [1:0] QPH_Q1 = 2'h0;
	localparam logic [1:0] QPH_Q2 = 2'h1;
	localparam logic [1:0] QPH_Q4 = 2'h3;

	typedef enum logic [1:0] {SPRS_EXEC, SPRS_NOP_CYC} sprs_state_e;

	typedef struct packed {
		logic [15:0] opcode;
		logic valid;
	} sprs_instr_s;

	typedef struct packed {
		logic [PC_W-1:0] pc;
		logic [PC_W-1:0] top_of_stack_entry;
		logic [STK_PTR_W-1:0] sp;
		logic [7:0] status;
		logic swreset;
	} sprs_core_s;
endpackage

// File: hw/sprs_core.sv
`timescale 1ns/100ps
// Contract
// - Push writes PC+2 to stack top, flags kept
// - Old top moves one level deeper
// - Call offset: 11-bit signed, -1024..1023
// - Call first pushes PC+2 as return
// - PC = PC+2+2n; two cycles, second idle
// - Software reset hits master-clear registers, one cycle
// - After software reset, values equal master-clear
module sprs_core #(
	parameter int DEPTH = sprs_pkg::STK_DEPTH
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire sprs_pkg::sprs_instr_s instr,
	input wire logic [7:0] status_in,
	input wire logic status_we,
	output sprs_pkg::sprs_core_s core,
	output logic [1:0] qphase,
	output logic busy
);
	import sprs_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [PC_W-1:0] pc_r, pc_nxt;
	logic [PC_W-1:0] stk_r [DEPTH];
	logic [PC_W-1:0] stk_nxt [DEPTH];
	logic [STK_PTR_W-1:0] sp_r, sp_nxt;
	logic [7:0] status_r, status_nxt;
	logic [1:0] q_r, q_nxt;
	sprs_state_e st_r, st_nxt;
	logic swrst_r, swrst_nxt;
	logic [PC_W-1:0] tgt_r, tgt_nxt;
	logic is_push, is_call, is_rst;

	function automatic logic [PC_W-1:0] call_target(input logic [PC_W-1:0] pc, input logic [15:0] op);
		logic [PC_W-1:0] off;
		off = {{(PC_W-REL_CALL_OFF_W){op[REL_CALL_OFF_W-1]}}, op[REL_CALL_OFF_W-1:0]};
		return pc + PC_STEP + (off << 1);
	endfunction

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	// Nothing is decoded in the idle half of a call
	always_comb begin
		is_push = instr.valid && st_r == SPRS_EXEC && instr.opcode == OP_PUSH;
		is_call = instr.valid && st_r == SPRS_EXEC && instr.opcode[15:11] == OP_REL_CALL_TOP;
		is_rst = instr.valid && st_r == SPRS_EXEC && instr.opcode == OP_SWRESET;
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		pc_nxt = pc_r;
		stk_nxt = stk_r;
		sp_nxt = sp_r;
		status_nxt = status_we ? status_in : status_r;
		q_nxt = q_r + 2'h1;
		st_nxt = st_r;
		swrst_nxt = 1'b0;
		tgt_nxt = tgt_r;
		// Push and call share the Q2 stack write
		if ((is_push || is_call) && q_r == QPH_Q2) begin
			for (int i = DEPTH - 1; i > 0; i--) begin
				stk_nxt[i] = stk_r[i-1];
			end
			stk_nxt[0] = pc_r + PC_STEP;
			// Full stack: deepest entry falls off, count saturates
			if (sp_r < STK_PTR_W'(DEPTH))
				sp_nxt = sp_r + 5'h01;
		end
		if (is_call && q_r == QPH_Q2)
			tgt_nxt = call_target(pc_r, instr.opcode);
		case (st_r)
			SPRS_EXEC: begin
				if (q_r == QPH_Q4) begin
					if (is_call) begin
						pc_nxt = tgt_r;
						st_nxt = SPRS_NOP_CYC;
					end else if (instr.valid && !is_rst) begin
						pc_nxt = pc_r + PC_STEP;
					end
				end
			end
			SPRS_NOP_CYC: begin
				if (q_r == QPH_Q4)
					st_nxt = SPRS_EXEC;
			end
			default: st_nxt = SPRS_EXEC;
		endcase
		// Software reset wins, same values as master clear
		if (is_rst && q_r == QPH_Q2) begin
			pc_nxt = PC_RST;
			sp_nxt = SP_RST;
			status_nxt = STATUS_RST;
			q_nxt = QPH_RST;
			st_nxt = SPRS_EXEC;
			swrst_nxt = 1'b1;
			tgt_nxt = PC_RST;
			for (int i = 0; i < DEPTH; i++)
				stk_nxt[i] = PC_RST;
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pc_r <= PC_RST;
			sp_r <= SP_RST;
			status_r <= STATUS_RST;
			q_r <= QPH_RST;
			st_r <= SPRS_EXEC;
			swrst_r <= 1'b0;
			tgt_r <= PC_RST;
			for (int i = 0; i < DEPTH; i++)
				stk_r[i] <= PC_RST;
		end else begin
			pc_r <= pc_nxt;
			sp_r <= sp_nxt;
			status_r <= status_nxt;
			q_r <= q_nxt;
			st_r <= st_nxt;
			swrst_r <= swrst_nxt;
			tgt_r <= tgt_nxt;
			stk_r <= stk_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			core <= '0;
			qphase <= QPH_RST;
			busy <= 1'b0;
		end else begin
			core <= '{
				pc: pc_nxt,
				top_of_stack_entry: stk_nxt[0],
				sp: sp_nxt,
				status: status_nxt,
				swreset: swrst_nxt
			};
			qphase <= q_nxt;
			busy <= (st_nxt == SPRS_NOP_CYC);
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	// Internal state is watched; outputs carry the same values
	a_push_top_value: assert property (
		is_push && q_r == QPH_Q2 |=> stk_r[0] == $past(pc_r) + PC_STEP)
		else $error("push top entry wrong");
	a_push_flags_kept: assert property (
		is_push && !status_we |=> status_r == $past(status_r))
		else $error("push changed flags");
	a_stack_shift_down: assert property (
		(is_push || is_call) && q_r == QPH_Q2 |=> stk_r[1] == $past(stk_r[0]))
		else $error("stack not shifted");
	a_call_ret_addr: assert property (
		is_call && q_r == QPH_Q2 |=> stk_r[0] == $past(pc_r) + PC_STEP)
		else $error("call return wrong");
	a_call_target_pc: assert property (
		is_call && q_r == QPH_Q2 |-> ##3 pc_r == $past(pc_r, 3) + PC_STEP
			+ {{(PC_W-REL_CALL_OFF_W-1){$past(instr.opcode[REL_CALL_OFF_W-1], 3)}},
			$past(instr.opcode[REL_CALL_OFF_W-1:0], 3), 1'b0})
		else $error("call target wrong");
	a_call_idle_cycle: assert property (
		is_call && q_r == QPH_Q4 |=> st_r == SPRS_NOP_CYC [*4] ##1 st_r == SPRS_EXEC)
		else $error("call second cycle wrong");
	a_swrst_values: assert property (
		is_rst && q_r == QPH_Q2 |=> pc_r == PC_RST && sp_r == SP_RST && status_r == STATUS_RST)
		else $error("reset values wrong");
	a_push_q2_only: assert property (
		q_r != QPH_Q2 |=> sp_r == $past(sp_r) && stk_r[0] == $past(stk_r[0]))
		else $error("stack write outside Q2");

	a_call_busy_flag: assert property (
		is_call && q_r == QPH_Q4 |=> busy [*4] ##1 !busy)
		else $error("busy not four cycles");
	a_idle_refuses: assert property (
		st_r == SPRS_NOP_CYC |=> pc_r == $past(pc_r) && sp_r == $past(sp_r) && stk_r[0] == $past(stk_r[0]))
		else $error("idle cycle acted");
	a_sp_counts_up: assert property (
		(is_push || is_call) && q_r == QPH_Q2 && sp_r != STK_PTR_W'(DEPTH) |=> sp_r == $past(sp_r) + 5'h01)
		else $error("depth not counted");
	a_push_one_cycle: assert property (
		is_push && q_r == QPH_Q4 |=> pc_r == $past(pc_r) + PC_STEP && st_r == SPRS_EXEC && q_r == QPH_Q1)
		else $error("push not one cycle");
	a_pc_q4_only: assert property (
		q_r != QPH_Q4 && !(is_rst && q_r == QPH_Q2) |=> pc_r == $past(pc_r))
		else $error("pc moved outside Q4");
	a_phase_steps: assert property (
		!(is_rst && q_r == QPH_Q2) |=> q_r == $past(q_r) + 2'h1)
		else $error("phase skipped");
	a_swrst_one_cycle: assert property (
		is_rst && q_r == QPH_Q2 |=> q_r == QPH_RST && swrst_r ##1 !swrst_r)
		else $error("reset pulse wrong");
	a_swrst_stack_clear: assert property (
		is_rst && q_r == QPH_Q2 |=> stk_r[0] == PC_RST && stk_r[DEPTH-1] == PC_RST && st_r == SPRS_EXEC)
		else $error("stack not cleared");
	a_swrst_outputs: assert property (
		is_rst && q_r == QPH_Q2 |=> core.swreset && core.pc == PC_RST && qphase == QPH_RST)
		else $error("reset outputs wrong");

	// Main scenarios
	c_push: cover property (is_push && q_r == QPH_Q2);
	c_call_neg: cover property (is_call && q_r == QPH_Q2 && instr.opcode[10]);
	c_call_pos: cover property (is_call && q_r == QPH_Q2 && !instr.opcode[10]);
	c_swrst: cover property (is_rst && q_r == QPH_Q2);
	c_idle_refused: cover property (st_r == SPRS_NOP_CYC && instr.valid);
endmodule // sprs_core

// File: bench/sprs_core_tb.sv
`timescale 1ns/100ps
module sprs_core_tb;
	import sprs_pkg::*;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	sprs_instr_s instr = '0;
	logic [7:0] status_in = 8'h00;
	logic status_we = 1'b0;
	sprs_core_s core;
	logic [1:0] qphase;
	logic busy;
	int num_errors = 0;
	int n_checks = 0;
	int cyc = 0;
	logic [31:0] seed = 32'h0000bfd5;
	logic [PC_W-1:0] e_pc = '0;
	logic [PC_W-1:0] e_top = '0;
	logic [4:0] e_sp = '0;
	logic [7:0] e_st = '0;
	sprs_core u_dut (.mclk(mclk), .rst_n(rst_n), .instr(instr), .status_in(status_in),
		.status_we(status_we), .core(core), .qphase(qphase), .busy(busy));
	always #4 mclk = ~mclk;
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] xs(logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	task automatic chk(logic ok, string msg);
		n_checks++;
		if (!ok) begin
			num_errors++;
			$display("MISMATCH %0t %s", $time, msg);
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// Hang guard well above the ~700 cycles the sequence needs
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 5000) begin
			num_errors++;
			give_verdict();
		end
	end
	task automatic step;
		@(posedge mclk);
		#1;
	endtask
	task automatic run(logic [15:0] op);
		int i;
		// One edge apart from the previous instruction's release
		step();
		for (i = 0; i < 8 && qphase !== QPH_Q1; i++) step();
		instr = '{opcode: op, valid: 1'b1};
		repeat (2) step();
		if (op === OP_SWRESET) begin
			instr.valid = 1'b0;
			chk(core.swreset === 1'b1 && core.pc === PC_RST && core.sp === SP_RST, "swreset");
			chk(core.status === STATUS_RST && qphase === QPH_RST, "rst val");
			chk(core.top_of_stack_entry === PC_RST, "rst top");
			e_pc = PC_RST;
			e_top = PC_RST;
			e_sp = SP_RST;
			e_st = STATUS_RST;
			return;
		end
		repeat (2) step();
		// A push offered in the idle half of a call must be ignored
		if (op[15:11] === OP_REL_CALL_TOP) instr.opcode = OP_PUSH;
		else instr.valid = 1'b0;
		e_top = e_pc + PC_STEP;
		e_sp = (e_sp == STK_DEPTH) ? e_sp : e_sp + 5'h01;
		e_pc = e_pc + PC_STEP;
		if (op[15:11] === OP_REL_CALL_TOP) e_pc = e_pc + {{9{op[10]}}, op[10:0], 1'b0};
		chk(core.top_of_stack_entry === e_top && core.sp === e_sp, "top");
		chk(core.pc === e_pc && core.status === e_st, "pc");
		if (op[15:11] === OP_REL_CALL_TOP) begin
			chk(busy === 1'b1, "busy");
			repeat (4) step();
			instr.valid = 1'b0;
			chk(busy === 1'b0 && core.pc === e_pc, "idle");
			chk(core.sp === e_sp && core.top_of_stack_entry === e_top, "refused");
		end
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		int i;
		repeat (12) step();
		rst_n = 1'b1;
		status_in = seed[7:0];
		status_we = 1'b1;
		step();
		status_we = 1'b0;
		e_st = status_in;
		run({OP_REL_CALL_TOP, 11'h400});
		run({OP_REL_CALL_TOP, 11'h3ff});
		for (i = 0; i < 70; i++) begin
			seed = xs(seed);
			if (seed[2:0] == 3'h0) run(OP_SWRESET);
			else if (seed[3]) run(OP_PUSH);
			else run({OP_REL_CALL_TOP, seed[20:10]});
		end
		give_verdict();
	end
endmodule // sprs_core_tb
